/* include/iadp_pkg.sv */
package iadp_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int IADP_XLEN   = 32;                     // Datapath width
   localparam int IADP_RIDX_W = 5;                      // Register index width

   // ****************************************
   // Field positions in the instruction word
   // ****************************************
   localparam int IADP_MAJ_LSB = 26;                    // Major opcode, 6 bits
   localparam int IADP_FB_LSB  = 21;                    // source_b / immediate dest
   localparam int IADP_FA_LSB  = 16;                    // source_a
   localparam int IADP_FD_LSB  = 11;                    // Register-form dest
   localparam int IADP_Z_BIT   = 10;                    // Must be zero, register add and AND
   localparam int IADP_BP_LSB  = 9;                     // byte_shift_count, 2 bits
   localparam int IADP_PCW_LSB = 19;                    // Two-bit PC minor
   localparam int IADP_PCU_LSB = 16;                    // Five-bit PC minor

   // ****************************************
   // Opcode values
   // ****************************************
   localparam logic [5:0] IADP_MAJ_GROUP_A   = 6'h00;   // major_group_a
   localparam logic [5:0] IADP_MAJ_PC_REL    = 6'h1E;   // pc_relative_group
   localparam logic [5:0] IADP_MAJ_ADD_IMM   = 6'h0C;   // add_imm_nontrap
   localparam logic [5:0] IADP_MAJ_AND_IMM   = 6'h34;   // and_imm_zext
   localparam logic [5:0] IADP_MAJ_ADD_UPPER = 6'h04;   // add_upper_imm
   localparam logic [9:0] IADP_MIN_ADD_REG   = 10'h150; // add_reg_nontrap
   localparam logic [9:0] IADP_MIN_AND_REG   = 10'h250; // Register AND
   localparam logic [5:0] IADP_MIN_CONCAT    = 6'h1F;   // byte_concat_extract, bits 5..0
   localparam logic [1:0] IADP_PCR_WORD      = 2'h0;    // pc_add_imm_word
   localparam logic [4:0] IADP_PCR_UPPER     = 5'h1E;   // pc_add_upper_imm
   localparam logic [4:0] IADP_PCR_UPPER_ALN = 5'h1F;   // pc_upper_add_64k_aligned

   // ****************************************
   // Masks and reset values
   // ****************************************
   localparam logic [31:0] IADP_WORD_MASK = 32'hFFFF_FFFC; // PC low two bits cleared
   localparam logic [31:0] IADP_64K_MASK  = 32'hFFFF_0000; // 64K alignment
   localparam logic [31:0] IADP_DATA_RST  = 32'h0000_0000; // Data reset value
   localparam logic [4:0]  IADP_ZERO_REG  = 5'h00;          // Hard-wired zero register

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      IADP_OP_NONE,
      IADP_OP_ADD_IMM,
      IADP_OP_ADD_REG,
      IADP_OP_PC_WORD,
      IADP_OP_CONCAT,
      IADP_OP_PC_UP_ALN,
      IADP_OP_AND_REG,
      IADP_OP_AND_IMM,
      IADP_OP_ADD_UPPER,
      IADP_OP_PC_UPPER
   } iadp_op_t;

   // Request from decoder and register file
   typedef struct packed {
      logic        valid;     // Request present
      logic [31:0] instr;     // Instruction word
      logic [31:0] pc;        // Address of this instruction
      logic [31:0] opa;       // source_a register value
      logic [31:0] opb;       // source_b register value
   } iadp_req_t;

   // Decoded instruction
   typedef struct packed {
      iadp_op_t    op;        // Operation
      logic [4:0]  dest;      // Destination register index
      logic [1:0]  bp;        // byte_shift_count
      logic [31:0] imm;       // Prepared immediate operand
   } iadp_dec_t;

   // Write-back answer
   typedef struct packed {
      logic        done;      // Answer on show, held until write-back takes it
      logic        wr;        // Register write required
      logic        bad;       // Word not handled here
      logic [4:0]  dest;      // Destination register index
      logic [31:0] data;      // Result
   } iadp_wb_t;

endpackage

/* src/iadp_decode.sv */
`timescale 1ns/1ps
// ****************************************
// Instruction decoder
// ****************************************
module iadp_decode
   import iadp_pkg::*;
(
   input  wire logic [31:0] instr,
   output iadp_dec_t        dec
);

   logic [5:0] maj;                                     // Major opcode
   logic [9:0] minor;                                   // Register-form minor
   logic [4:0] fb;                                      // Field at 25..21
   logic [4:0] fd;                                      // Field at 15..11

   assign maj   = instr[IADP_MAJ_LSB +: 6];
   assign minor = instr[9:0];
   assign fb    = instr[IADP_FB_LSB +: IADP_RIDX_W];
   assign fd    = instr[IADP_FD_LSB +: IADP_RIDX_W];

   // Pick the operation and shape its immediate
   always_comb begin
      dec      = '{op: IADP_OP_NONE, dest: fb, bp: instr[IADP_BP_LSB +: 2], imm: '0};
      case (maj)
         IADP_MAJ_GROUP_A: begin
            dec.dest = fd;
            if (!instr[IADP_Z_BIT] && minor == IADP_MIN_ADD_REG) begin
               dec.op = IADP_OP_ADD_REG;
            end else if (!instr[IADP_Z_BIT] && minor == IADP_MIN_AND_REG) begin
               dec.op = IADP_OP_AND_REG;
            end else if (minor[5:0] == IADP_MIN_CONCAT) begin
               dec.op = IADP_OP_CONCAT;
            end
         end
         IADP_MAJ_PC_REL: begin
            if (instr[IADP_PCW_LSB +: 2] == IADP_PCR_WORD) begin
               dec.op  = IADP_OP_PC_WORD;
               dec.imm = {{11{instr[18]}}, instr[18:0], 2'b00};
            end else if (instr[IADP_PCU_LSB +: 5] == IADP_PCR_UPPER_ALN) begin
               dec.op  = IADP_OP_PC_UP_ALN;
               dec.imm = {instr[15:0], 16'h0000};
            end else if (instr[IADP_PCU_LSB +: 5] == IADP_PCR_UPPER) begin
               dec.op  = IADP_OP_PC_UPPER;
               dec.imm = {instr[15:0], 16'h0000};
            end
         end
         IADP_MAJ_ADD_IMM: begin
            dec.op  = IADP_OP_ADD_IMM;
            dec.imm = {{16{instr[15]}}, instr[15:0]};
         end
         IADP_MAJ_AND_IMM: begin
            dec.op  = IADP_OP_AND_IMM;
            dec.imm = {16'h0000, instr[15:0]};
         end
         IADP_MAJ_ADD_UPPER: begin
            dec.op  = IADP_OP_ADD_UPPER;
            dec.imm = {instr[15:0], 16'h0000};
         end
         default: begin
            dec.op = IADP_OP_NONE;                      // Not ours
         end
      endcase
   end

endmodule

/* src/iadp_concat.sv */
`timescale 1ns/1ps
// ****************************************
// Byte concatenate-and-extract
// ****************************************
module iadp_concat
   import iadp_pkg::*;
(
   input  wire logic [31:0] hi_word,                    // source_b
   input  wire logic [31:0] lo_word,                    // source_a
   input  wire logic [1:0]  count,                      // byte_shift_count
   output logic      [31:0] res
);

   // A zero count would need a 32-bit right shift; it is split out so the
   // result is simply hi_word, a plain move
   always_comb begin
      case (count)
         2'h0:    res = hi_word;
         2'h1:    res = {hi_word[23:0], 8'h00}  | {24'h0, lo_word[31:24]};
         2'h2:    res = {hi_word[15:0], 16'h0000} | {16'h0, lo_word[31:16]};
         2'h3:    res = {hi_word[7:0], 24'h0}   | {8'h00, lo_word[31:8]};
         default: res = hi_word;
      endcase
   end

endmodule

/* src/iadp_top.sv */
`timescale 1ns/1ps
// ****************************************
// Integer add, logic and PC-relative execute stage
// ****************************************
module iadp_top
   import iadp_pkg::*;
#(
   parameter int DATA_W = IADP_XLEN                     // Only 32 is served
)
(
   input  wire logic      CLK,
   input  wire logic      NRST,
   input  iadp_req_t      REQ,
   output logic           REQ_READY,
   output iadp_wb_t       WB,
   input  wire logic      WB_READY
);

   // ****************************************
   // Elaboration check
   // ****************************************
   if (DATA_W != IADP_XLEN) begin : g_bad_width
      $error("iadp_top serves a 32-bit datapath only");
   end

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      iadp_req_t stage;                                 // Registered operands
      iadp_wb_t  wb;                                    // Registered answer
   } iadp_state_t;

   iadp_state_t st_r;                                   // Current state
   iadp_state_t st_nxt;                                 // Next state
   iadp_dec_t   dec;                                    // Decode of staged word
   logic [31:0] concat_res;                             // Concat unit result
   logic [31:0] result;                                 // Selected result
   logic        wb_free;                                // Answer slot can load
   logic        known;                                  // Operation recognised

   // ****************************************
   // Decode and concat units
   // ****************************************
   iadp_decode u_decode (
      .instr (st_r.stage.instr),
      .dec   (dec)
   );

   iadp_concat u_concat (
      .hi_word (st_r.stage.opb),
      .lo_word (st_r.stage.opa),
      .count   (dec.bp),
      .res     (concat_res)
   );

   // ****************************************
   // Result selection
   // ****************************************
   // All sums are 32 bits wide, so a carry out of bit 31 is simply lost;
   // no overflow is ever flagged
   always_comb begin
      known  = 1'b1;
      result = IADP_DATA_RST;
      case (dec.op)
         IADP_OP_ADD_IMM: begin
            result = st_r.stage.opa + dec.imm;
         end
         IADP_OP_ADD_REG: begin
            result = st_r.stage.opa + st_r.stage.opb;
         end
         IADP_OP_PC_WORD: begin
            result = (st_r.stage.pc & IADP_WORD_MASK) + dec.imm;
         end
         IADP_OP_CONCAT: begin
            result = concat_res;
         end
         IADP_OP_PC_UP_ALN: begin
            result = (st_r.stage.pc + dec.imm) & IADP_64K_MASK;
         end
         IADP_OP_AND_REG: begin
            result = st_r.stage.opa & st_r.stage.opb;
         end
         IADP_OP_AND_IMM: begin
            result = st_r.stage.opa & dec.imm;
         end
         IADP_OP_ADD_UPPER: begin
            // A zero source_a gives the load-upper form for free
            result = st_r.stage.opa + dec.imm;
         end
         IADP_OP_PC_UPPER: begin
            result = st_r.stage.pc + dec.imm;
         end
         default: begin
            known = 1'b0;                               // Left to another unit
         end
      endcase
   end

   // ****************************************
   // Flow control
   // ****************************************
   // The answer slot loads when empty or when write-back takes it
   assign wb_free   = !st_r.wb.done || WB_READY;
   // A new request enters when the stage is empty or moves on this cycle
   assign REQ_READY = !st_r.stage.valid || wb_free;
   assign WB        = st_r.wb;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      // Answer leaves when write-back takes it
      if (st_r.wb.done && WB_READY) begin
         st_nxt.wb.done = 1'b0;
         st_nxt.wb.wr   = 1'b0;
         st_nxt.wb.bad  = 1'b0;
      end
      // Staged word computes in one cycle into the answer slot
      if (st_r.stage.valid && wb_free) begin
         st_nxt.wb.done = 1'b1;
         st_nxt.wb.bad  = !known;
         st_nxt.wb.dest = dec.dest;
         st_nxt.wb.data = result;
         // Register zero is never written
         st_nxt.wb.wr   = known && (dec.dest != IADP_ZERO_REG);
         st_nxt.stage.valid = 1'b0;
      end
      // Capture a new request
      if (REQ.valid && REQ_READY) begin
         st_nxt.stage = REQ;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

/* testbench/iadp_chk_sva.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker for the execute stage
// ****************************************
module iadp_chk
   import iadp_pkg::*;
(
   input  wire logic CLK,
   input  wire logic NRST,
   input  iadp_req_t REQ,
   input  wire logic REQ_READY,
   input  iadp_wb_t  WB,
   input  wire logic WB_READY
);
   iadp_req_t  q_r [4];  // Taken requests, oldest at rd_r
   logic [1:0] wp_r;     // Write slot
   logic [1:0] rd_r;     // Slot of the answer on show
   iadp_req_t  hd;       // Request behind the answer
   logic [5:0] mj;       // Its major opcode
   assign hd = q_r[rd_r];
   assign mj = hd.instr[31:26];
   // Two in flight at most, so four slots never overrun a live one
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         wp_r <= 2'h0;
         rd_r <= 2'h0;
      end else begin
         if (REQ.valid && REQ_READY) begin
            q_r[wp_r] <= REQ;
            wp_r      <= wp_r + 2'h1;
         end
         if (WB.done && WB_READY) begin
            rd_r <= rd_r + 2'h1;
         end
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // ****************************************
   // Assertions
   // ****************************************
   AST_RST: assert property ($rose(NRST) |-> !WB.done && !WB.wr)
      else $error("answer shown just after reset");
   AST_HOLD: assert property (WB.done && !WB_READY |=> WB.done && $stable(WB))
      else $error("answer changed while stalled");
   AST_LAT: assert property (REQ.valid && REQ_READY |-> ##[1:12] WB.done)
      else $error("no answer for taken request");
   AST_ZERO: assert property (WB.done && WB.dest == IADP_ZERO_REG |-> !WB.wr)
      else $error("write to register zero");
   AST_ADDI: assert property (WB.done && WB.wr && mj == IADP_MAJ_ADD_IMM |->
      WB.data == hd.opa + {{16{hd.instr[15]}}, hd.instr[15:0]}) else $error("imm add wrong");
   AST_ADDR: assert property (WB.done && WB.wr && mj == IADP_MAJ_GROUP_A &&
      hd.instr[10:0] == {1'b0, IADP_MIN_ADD_REG} |-> WB.data == hd.opa + hd.opb
      && WB.dest == hd.instr[15:11]) else $error("register add wrong");
   AST_ANDR: assert property (WB.done && WB.wr && mj == IADP_MAJ_GROUP_A &&
      hd.instr[10:0] == {1'b0, IADP_MIN_AND_REG} |-> WB.data == (hd.opa & hd.opb))
      else $error("register and wrong");
   AST_AND_IMM_ZEXT: assert property (WB.done && WB.wr && mj == IADP_MAJ_AND_IMM |->
      WB.data[31:16] == 16'h0000 && WB.dest == hd.instr[25:21]) else $error("and imm wrong");
   AST_UPPER: assert property (WB.done && WB.wr && mj == IADP_MAJ_ADD_UPPER |->
      WB.data == hd.opa + {hd.instr[15:0], 16'h0000}) else $error("upper add wrong");
   AST_PCW: assert property (WB.done && WB.wr && mj == IADP_MAJ_PC_REL &&
      hd.instr[20:19] == IADP_PCR_WORD |-> WB.data == (hd.pc & IADP_WORD_MASK)
      + {{11{hd.instr[18]}}, hd.instr[18:0], 2'h0}) else $error("pc word add wrong");
   AST_ALN: assert property (WB.done && WB.wr && mj == IADP_MAJ_PC_REL &&
      hd.instr[20:16] == IADP_PCR_UPPER_ALN |-> WB.data[15:0] == 16'h0000)
      else $error("aligned pc add not aligned");
   // Main scenarios reached
   COV_STALL: cover property (WB.done && !WB_READY);
   COV_B2B: cover property (REQ.valid && REQ_READY ##1 REQ.valid && REQ_READY);
   COV_BAD: cover property (WB.done && WB.bad);
endmodule
bind iadp_top iadp_chk u_chk (.CLK(CLK), .NRST(NRST), .REQ(REQ), .REQ_READY(REQ_READY),
   .WB(WB), .WB_READY(WB_READY));

/* testbench/iadp_wb_sink.sv */
`timescale 1ns/1ps
// ****************************************
// Write-back side model
// ****************************************
module iadp_wb_sink (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic slow,
   output logic      wb_ready
);
   logic [1:0] cnt_r;  // Phase of the slow accept pattern
   // Slow mode accepts one cycle in three so answers back up
   always_ff @(posedge clk) begin
      if (!nrst || cnt_r == 2'h2) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   assign wb_ready = !slow || (cnt_r == 2'h2);
endmodule

/* testbench/tb_int_add_logic_pc_relative_group_datapath.sv */
`timescale 1ns/1ps
module tb_int_add_logic_pc_relative_group_datapath
   import iadp_pkg::*;
;
   logic      CLK;
   logic      NRST;
   iadp_req_t REQ;
   logic      REQ_READY;
   iadp_wb_t  WB;
   logic      WB_READY;
   logic      slow;          // Stall the write-back side
   int        fail_count;
   int        total_checks;
   iadp_wb_t  eq[$];         // Answers still owed, oldest first
   iadp_wb_t  e;             // Answer being judged

   iadp_top dut (.CLK(CLK), .NRST(NRST), .REQ(REQ), .REQ_READY(REQ_READY), .WB(WB),
      .WB_READY(WB_READY));
   iadp_wb_sink sink (.clk(CLK), .nrst(NRST), .slow(slow), .wb_ready(WB_READY));

   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end

   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic iadp_wb_t ex(logic [4:0] d, logic [31:0] r);
      return '{1'b1, d != IADP_ZERO_REG, 1'b0, d, r};
   endfunction
   function automatic logic [31:0] iw(logic [5:0] m, logic [4:0] b, logic [4:0] a,
                                      logic [15:0] k);
      return {m, b, a, k};
   endfunction
   function automatic logic [31:0] rw(logic [4:0] b, logic [4:0] a, logic [4:0] d,
                                      logic [10:0] lo);
      return {IADP_MAJ_GROUP_A, b, a, d, lo};
   endfunction

   // Judge each answer in the cycle that write-back takes it, before the edge
   always @(negedge CLK) begin
      if (NRST === 1'b1 && WB.done === 1'b1 && WB_READY === 1'b1) begin
         if (eq.size() == 0) begin
            chk("unexpected answer", 64'h1, 64'h0);
         end else begin
            e = eq.pop_front();
            if (e.wr) begin
               chk("answer", WB, e);
            end else begin
               chk("flags", {WB.done, WB.wr, WB.bad}, {e.done, e.wr, e.bad});
            end
         end
      end
   end

   // Request held until taken; the next one may follow at once
   task automatic issue(logic [31:0] i, logic [31:0] p, logic [31:0] a, logic [31:0] b,
                        iadp_wb_t x);
      eq.push_back(x);
      REQ <= '{1'b1, i, p, a, b};
      @(negedge CLK);
      for (int n = 0; n < 40 && REQ_READY !== 1'b1; n++) @(negedge CLK);
      @(posedge CLK);
   endtask

   // Released lines show inverted data, not stale operands
   task automatic drain();
      REQ <= {1'b0, ~REQ[127:0]};
      for (int n = 0; n < 60 && eq.size() != 0; n++) @(posedge CLK);
      chk("answers owed", eq.size(), 64'h0);
   endtask

   task automatic t_add();
      issue(iw(IADP_MAJ_ADD_IMM, 5'h03, 5'h01, 16'h0020), 0, 32'h7FFF_FFF0, 0, ex(3, 32'h8000_0010));
      issue(iw(IADP_MAJ_ADD_IMM, 5'h04, 5'h01, 16'hFFF0), 0, 32'h5, 0, ex(4, 32'hFFFF_FFF5));
      issue(rw(5'h02, 5'h01, 5'h05, {1'b0, IADP_MIN_ADD_REG}), 0, 32'hFFFF_FFFF, 2, ex(5, 1));
      issue(rw(5'h02, 5'h01, 5'h05, {1'b1, IADP_MIN_ADD_REG}), 0, 1, 2, '{1, 0, 1, 0, 0});
      drain();
   endtask

   task automatic t_logic();
      issue(rw(5'h02, 5'h01, 5'h06, {1'b0, IADP_MIN_AND_REG}), 0, 32'hF0F0_1234, 32'h0FF0_FF00, ex(6, 32'h00F0_1200));
      issue(iw(IADP_MAJ_AND_IMM, 5'h07, 5'h01, 16'h8F0F), 0, 32'hFFFF_FFFF, 0, ex(7, 32'h8F0F));
      issue(rw(5'h02, 5'h01, 5'h06, {1'b1, IADP_MIN_AND_REG}), 0, 1, 1, '{1, 0, 1, 0, 0});
      drain();
   endtask

   // Stalled write-back while upper adds flow back to back
   task automatic t_upper();
      slow <= 1'b1;
      issue(iw(IADP_MAJ_ADD_UPPER, 5'h08, 5'h01, 16'h8001), 0, 32'h1234, 0, ex(8, 32'h8001_1234));
      issue(iw(IADP_MAJ_ADD_UPPER, 5'h09, 5'h01, 16'h8000), 0, 32'h8000_0000, 0, ex(9, 0));
      issue(iw(IADP_MAJ_ADD_UPPER, 5'h0A, 5'h00, 16'hABCD), 0, 0, 0, ex(10, 32'hABCD_0000));
      // Paired large-offset sequence: the second reads what the first wrote
      issue(iw(IADP_MAJ_ADD_UPPER, 5'h0B, 5'h01, 16'h0001), 0, 32'h10, 0, ex(11, 32'h1_0010));
      issue(iw(IADP_MAJ_ADD_IMM, 5'h0C, 5'h0B, 16'h0004), 0, 32'h1_0010, 0, ex(12, 32'h1_0014));
      drain();
      slow <= 1'b0;
   endtask

   task automatic t_pc();
      issue(iw(IADP_MAJ_PC_REL, 5'h0D, 5'h07, 16'hFFFF), 32'h1003, 0, 0, ex(13, 32'h0FFC));
      issue(iw(IADP_MAJ_PC_REL, 5'h0E, 5'h00, 16'h0010), 32'h2000_0002, 0, 0, ex(14, 32'h2000_0040));
      issue(iw(IADP_MAJ_PC_REL, 5'h0F, IADP_PCR_UPPER, 16'hFFFF), 32'h1234_5678, 0, 0, ex(15, 32'h1233_5678));
      issue(iw(IADP_MAJ_PC_REL, 5'h11, IADP_PCR_UPPER_ALN, 16'h0001), 32'h1234_5678, 0, 0, ex(17, 32'h1235_0000));
      drain();
   endtask

   // Every count, zero included, since it must still give a defined move
   task automatic t_concat();
      logic [31:0] a;
      logic [31:0] b;
      a = 32'h1122_3344;
      b = 32'hAABB_CCDD;
      for (int k = 0; k < 4; k++) begin
         issue(rw(5'h02, 5'h01, 5'h10, {k[1:0], 3'h0, IADP_MIN_CONCAT}), 0, a, b, ex(16, (b << (8 * k)) | (a >> (8 * (4 - k)))));
      end
      drain();
   endtask

   task automatic t_zero();
      issue(rw(5'h02, 5'h01, 5'h00, {1'b0, IADP_MIN_ADD_REG}), 0, 1, 2, ex(0, 3));
      issue(iw(6'h3F, 5'h03, 5'h01, 16'h0001), 0, 1, 1, '{1, 0, 1, 0, 0});
      drain();
   endtask

   // Reset in mid-flight drops the pending answer
   task automatic t_reset();
      issue(iw(IADP_MAJ_ADD_IMM, 5'h03, 5'h01, 16'h0001), 0, 1, 0, ex(3, 2));
      NRST <= 1'b0;
      REQ  <= {1'b0, ~REQ[127:0]};
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      eq.delete();
      // Judge after the first edge out of reset, where a lost answer could return
      @(posedge CLK);
      @(negedge CLK);
      chk("done after reset", WB.done, 64'h0);
      chk("ready after reset", REQ_READY, 64'h1);
      @(posedge CLK);
   endtask

   task automatic conclude();
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      NRST         = 1'b0;
      slow         = 1'b0;
      REQ          = '0;
      fail_count   = 0;
      total_checks = 0;
      repeat (4) @(posedge CLK);
      NRST <= 1'b1;
      @(posedge CLK);
      t_add();
      t_logic();
      t_upper();
      t_pc();
      t_concat();
      t_zero();
      t_reset();
      conclude();
   end

   // Whole run needs under a hundred cycles; the 4000-cycle limit is far beyond
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
endmodule
